// file: common/stc_pkg.sv
// Purpose: Shared constants and types for the standard timer block
// Assumes: APB with 32-bit data; each register takes one aligned word
// Notes:   Narrow registers sit in the low byte, upper bits read zero
package stc_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] OFS_CONTROL0  = 8'h00;
  localparam logic [7:0] OFS_CONTROL1  = 8'h04;
  localparam logic [7:0] OFS_CNT_LOW   = 8'h08;
  localparam logic [7:0] OFS_CNT_HIGH  = 8'h0c;
  localparam logic [7:0] OFS_CMPA_LOW  = 8'h10;
  localparam logic [7:0] OFS_CMPA_HIGH = 8'h14;
  localparam logic [7:0] OFS_CMPP      = 8'h18;
  localparam logic [7:0] OFS_FLAGS     = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int BIT_PAUSE     = 7;
  localparam int BIT_CLK_HI    = 6;
  localparam int BIT_CLK_LO    = 4;
  localparam int BIT_ON        = 3;
  localparam int BIT_A_FLAG    = 0;
  localparam int BIT_P_FLAG    = 1;
  localparam logic [7:0] CONTROL0_MASK = 8'hf8;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ==========================================================
  // Modes, pin functions and clock sources
  localparam logic [1:0] MODE_COMPARE = 2'b00;
  localparam logic [1:0] MODE_PWM     = 2'b10;
  localparam logic [1:0] MODE_TIMER   = 2'b11;
  localparam logic [1:0] FN_NONE      = 2'b00;
  localparam logic [1:0] FN_LOW       = 2'b01;
  localparam logic [1:0] FN_HIGH      = 2'b10;
  localparam logic [1:0] FN_TOGGLE    = 2'b11;
  localparam logic [1:0] FN_PWM_OFF   = 2'b00;
  localparam logic [1:0] FN_PWM_ON    = 2'b01;
  localparam logic [1:0] FN_PWM       = 2'b10;
  localparam logic [2:0] CK_DIV4      = 3'b000;
  localparam logic [2:0] CK_DIV1      = 3'b001;
  localparam logic [2:0] CK_DIV16     = 3'b010;
  localparam logic [2:0] CK_DIV64     = 3'b011;
  localparam logic [2:0] CK_SUB_A     = 3'b100;
  localparam logic [2:0] CK_SUB_B     = 3'b101;
  localparam logic [2:0] CK_EXT_RISE  = 3'b110;
  localparam logic [2:0] CK_EXT_FALL  = 3'b111;
  localparam logic [7:0] MSK_DIV4     = 8'h03;
  localparam logic [7:0] MSK_DIV16    = 8'h0f;
  localparam logic [7:0] MSK_DIV64    = 8'h3f;
  localparam logic [7:0] MSK_SUB      = 8'hff;

  // ==========================================================
  // Mode control byte as a struct, msb first
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] pin_function;
    logic       output_control;
    logic       output_polarity;
    logic       duty_period_swap;
    logic       clear_select;
  } stc_ctrl1_t;

endpackage

// file: hw/stc_timer.sv
// Purpose: Sixteen-bit standard timer with compare A/P and edge PWM
// Assumes: Single clock pclk at 10 MHz; external count pin synchronous
// Notes:   Registers reached over APB, zero wait state, no interrupt
//
// What this block does
// R1: Counter bits 15..8 readable in a read-only byte, reset zero.
// R2: Compare A is 16 bits in two read/write bytes, reset zero.
// R3: Compare P is 8 bits, matched against counter bits 15..8 only.
// R4: P match period is 65536 clocks for 0, else value times 256.
// R5: Clear-select low clears on P match; P of zero wraps at maximum.
// R6: Mode selector 00 selects compare-match output mode.
// R7: Compare mode, clear-select low: clear on P or overflow, both flags.
// R8: Compare mode, clear-select high: clear on A match, A flag only.
// R9: Software must not set compare A to zero in compare mode.
// R10: Pin changes only on A match, per function field; 00 no change.
// R11: P match never changes the pin in compare mode.
// R12: Counter-on rising edge forces pin to the output-control level.
// R13: Mode 11 counts and flags like compare mode, pin not driven.
// R14: Mode 10 with function 10 makes a PWM generator.
// R15: PWM ignores clear-select; swap bit picks period and duty registers.
// R16: Swap 0: period P times 256 (65536 for 0), duty equals A.
// R17: Duty at or above period gives full active output.
// R18: Swap 1: period from A, duty P times 256, P zero special.
// R19: PWM raises A flag on A match and P flag on P match.
// R20: Output-control sets active level, function forces, polarity inverts.
// R21: PWM counter keeps running while the pin is forced.
// R22: Counter-on rising clears the counter; falling holds its value.
// R23: Pause freezes the counter; clearing resumes from that value.
// R24: Compare function: 00 none, 01 low, 10 high, 11 toggle.
// R25: Counter increments once per selected tick while on and not paused.
// R26: A match uses all 16 bits; its match pulse lasts one pclk cycle.
`timescale 1ns/1ns
`default_nettype none

module stc_timer
#(
  parameter int PCLK_HZ = 10000000
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External count clock, synchronous to pclk
  input  wire logic        count_pin_in,
  // Timer output pin
  output logic             timer_out,
  output logic             timer_out_en,
  // Match events, one pclk cycle long
  output logic             a_match_pulse,
  output logic             p_match_pulse
);

  // ==========================================================
  // Helpers
  // True when the masked prescaler bits are all ones
  function automatic logic div_hit(input logic [7:0] cnt,
                                   input logic [7:0] msk);
    div_hit = ((cnt & msk) == msk);
  endfunction

  // Known register address
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == stc_pkg::OFS_CONTROL0)  || (a == stc_pkg::OFS_CONTROL1)
           || (a == stc_pkg::OFS_CNT_LOW)   || (a == stc_pkg::OFS_CNT_HIGH)
           || (a == stc_pkg::OFS_CMPA_LOW)  || (a == stc_pkg::OFS_CMPA_HIGH)
           || (a == stc_pkg::OFS_CMPP)      || (a == stc_pkg::OFS_FLAGS);
  endfunction

  // ==========================================================
  // State
  logic [7:0]          ctrl0_reg, ctrl0_next;
  stc_pkg::stc_ctrl1_t ctrl1_reg, ctrl1_next;
  logic [15:0]         cmpa_reg, cmpa_next;
  logic [7:0]          cmpp_reg, cmpp_next;
  logic [15:0]         cnt_reg, cnt_next;
  logic [7:0]          pre_reg, pre_next;
  logic                on_d_reg, on_d_next;
  logic                pin_d_reg, pin_d_next;
  logic                lvl_reg, lvl_next;
  logic                out_reg, out_next;
  logic                oen_reg, oen_next;
  logic [1:0]          flag_reg, flag_next;
  logic                apulse_reg, apulse_next;
  logic                ppulse_reg, ppulse_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic                err_reg, err_next;

  // ==========================================================
  // Combinational decode
  logic        wr_en, setup_ph, on, pause, tick, on_rise, clr;
  logic        a_hit, p_hit, pwm_act, act_lvl;
  logic [16:0] inc;
  logic [2:0]  ck_sel;

  assign setup_ph = psel && !penable;
  // Writes land at the access edge only, as APB requires
  assign wr_en    = psel && penable && pwrite && addr_ok(paddr);
  assign on       = ctrl0_reg[stc_pkg::BIT_ON];
  assign pause    = ctrl0_reg[stc_pkg::BIT_PAUSE];
  assign ck_sel   = ctrl0_reg[stc_pkg::BIT_CLK_HI:stc_pkg::BIT_CLK_LO];
  assign on_rise  = on && !on_d_reg;
  assign inc      = {1'b0, cnt_reg} + 17'h00001;

  // Tick source; sub clock modelled by a divide by 256
  always_comb
  begin
    case (ck_sel)
      stc_pkg::CK_DIV4:     tick = div_hit(pre_reg, stc_pkg::MSK_DIV4);
      stc_pkg::CK_DIV1:     tick = 1'b1;
      stc_pkg::CK_DIV16:    tick = div_hit(pre_reg, stc_pkg::MSK_DIV16);
      stc_pkg::CK_DIV64:    tick = div_hit(pre_reg, stc_pkg::MSK_DIV64);
      stc_pkg::CK_EXT_RISE: tick = count_pin_in && !pin_d_reg;
      stc_pkg::CK_EXT_FALL: tick = !count_pin_in && pin_d_reg;
      default:              tick = div_hit(pre_reg, stc_pkg::MSK_SUB);
    endcase
  end

  // Matches look at the value the counter is about to take, so a
  // P value n clears after n*256 ticks and zero waits for overflow
  assign a_hit = on && !pause && !on_rise && tick
              && (inc == {1'b0, cmpa_reg});                        // [R26]
  assign p_hit = on && !pause && !on_rise && tick
              && ((cmpp_reg == stc_pkg::RST_BYTE) ? inc[16]
                  : (inc == {1'b0, cmpp_reg, 8'h00}));       // [R3] [R4]

  // Clear source: PWM ignores clear-select
  always_comb
  begin
    if (ctrl1_reg.mode_select == stc_pkg::MODE_PWM)
      clr = ctrl1_reg.duty_period_swap ? a_hit : p_hit;         // [R15]
    else
      clr = ctrl1_reg.clear_select ? a_hit : p_hit;   // [R5] [R7] [R8]
  end

  // Edge-aligned PWM: active while the count is below the duty
  always_comb
  begin
    if (!ctrl1_reg.duty_period_swap)
      pwm_act = (cnt_reg < cmpa_reg);                     // [R16] [R17]
    else if (cmpp_reg == stc_pkg::RST_BYTE)
      pwm_act = 1'b1;                                           // [R18]
    else
      pwm_act = (cnt_reg < {cmpp_reg, 8'h00});            // [R18] [R17]
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    ctrl0_next  = ctrl0_reg;
    ctrl1_next  = ctrl1_reg;
    cmpa_next   = cmpa_reg;
    cmpp_next   = cmpp_reg;
    cnt_next    = cnt_reg;
    pre_next    = pre_reg + 8'h01;
    on_d_next   = on;
    pin_d_next  = count_pin_in;
    lvl_next    = lvl_reg;
    out_next    = out_reg;
    oen_next    = oen_reg;
    flag_next   = flag_reg;
    apulse_next = 1'b0;
    ppulse_next = 1'b0;
    rdata_next  = rdata_reg;
    err_next    = 1'b0;
    act_lvl     = 1'b0;

    // Register writes; flags clear by writing ones
    if (wr_en)
    begin
      case (paddr)
        stc_pkg::OFS_CONTROL0:
          ctrl0_next = pwdata[7:0] & stc_pkg::CONTROL0_MASK;
        stc_pkg::OFS_CONTROL1:  ctrl1_next = pwdata[7:0];
        stc_pkg::OFS_CMPA_LOW:  cmpa_next[7:0] = pwdata[7:0];      // [R2]
        stc_pkg::OFS_CMPA_HIGH: cmpa_next[15:8] = pwdata[7:0];     // [R2]
        stc_pkg::OFS_CMPP:      cmpp_next = pwdata[7:0];           // [R3]
        stc_pkg::OFS_FLAGS:     flag_next = flag_reg & ~pwdata[1:0];
        default:                flag_next = flag_reg;
      endcase
    end

    // Counter: restart on enable edge, hold when off or paused
    if (on_rise)
      cnt_next = stc_pkg::RST_WORD;                                // [R22]
    else if (on && !pause && tick)                           // [R23] [R25]
      cnt_next = clr ? stc_pkg::RST_WORD : inc[15:0];            // [R21]

    // Events; P flag suppressed in compare modes with A clearing
    if (a_hit)
    begin
      apulse_next = 1'b1;                                    // [R19] [R26]
      flag_next[stc_pkg::BIT_A_FLAG] = 1'b1;         // set beats clear
    end
    if (p_hit && (ctrl1_reg.mode_select == stc_pkg::MODE_PWM
                  || !ctrl1_reg.clear_select))             // [R8] [R19]
    begin
      ppulse_next = 1'b1;                                    // [R7] [R13]
      flag_next[stc_pkg::BIT_P_FLAG] = 1'b1;
    end

    // Compare-mode level: reset on enable edge, changed by A only
    if (on_rise)
      lvl_next = ctrl1_reg.output_control;                         // [R12]
    else if (a_hit)                                          // [R10] [R11]
    begin
      case (ctrl1_reg.pin_function)                                // [R24]
        stc_pkg::FN_LOW:    lvl_next = 1'b0;
        stc_pkg::FN_HIGH:   lvl_next = 1'b1;
        stc_pkg::FN_TOGGLE: lvl_next = !lvl_reg;
        default:            lvl_next = lvl_reg;
      endcase
    end

    // Pin drive per mode; timer mode and the unused mode 01 leave it free
    case (ctrl1_reg.mode_select)
      stc_pkg::MODE_COMPARE:                                        // [R6]
      begin
        oen_next = 1'b1;
        out_next = lvl_next ^ ctrl1_reg.output_polarity;
      end
      stc_pkg::MODE_PWM:                                     // [R14] [R20]
      begin
        oen_next = 1'b1;
        case (ctrl1_reg.pin_function)
          stc_pkg::FN_PWM_ON: act_lvl = 1'b1;                      // [R21]
          stc_pkg::FN_PWM:    act_lvl = pwm_act;
          default:            act_lvl = 1'b0;
        endcase
        out_next = (ctrl1_reg.output_control ? act_lvl : !act_lvl)
                 ^ ctrl1_reg.output_polarity;                      // [R20]
      end
      default:                                                     // [R13]
      begin
        oen_next = 1'b0;
        out_next = 1'b0;
      end
    endcase

    // Read data captured in the setup phase, answered next edge
    if (setup_ph)
    begin
      err_next = !addr_ok(paddr);
      case (paddr)
        stc_pkg::OFS_CONTROL0:  rdata_next = {24'h000000, ctrl0_reg};
        stc_pkg::OFS_CONTROL1:  rdata_next = {24'h000000, ctrl1_reg};
        stc_pkg::OFS_CNT_LOW:   rdata_next = {24'h000000, cnt_reg[7:0]};
        stc_pkg::OFS_CNT_HIGH:
          rdata_next = {24'h000000, cnt_reg[15:8]};                 // [R1]
        stc_pkg::OFS_CMPA_LOW:  rdata_next = {24'h000000, cmpa_reg[7:0]};
        stc_pkg::OFS_CMPA_HIGH: rdata_next = {24'h000000, cmpa_reg[15:8]};
        stc_pkg::OFS_CMPP:      rdata_next = {24'h000000, cmpp_reg};
        stc_pkg::OFS_FLAGS:     rdata_next = {30'h0, flag_reg};
        default:                rdata_next = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_reg  <= stc_pkg::RST_BYTE;
      ctrl1_reg  <= stc_pkg::RST_BYTE;
      cmpa_reg   <= stc_pkg::RST_WORD;
      cmpp_reg   <= stc_pkg::RST_BYTE;
      cnt_reg    <= stc_pkg::RST_WORD;                              // [R1]
      pre_reg    <= stc_pkg::RST_BYTE;
      on_d_reg   <= 1'b0;
      pin_d_reg  <= 1'b0;
      lvl_reg    <= 1'b0;
      out_reg    <= 1'b0;
      oen_reg    <= 1'b0;
      flag_reg   <= 2'b00;
      apulse_reg <= 1'b0;
      ppulse_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      err_reg    <= 1'b0;
    end
    else
    begin
      ctrl0_reg  <= ctrl0_next;
      ctrl1_reg  <= ctrl1_next;
      cmpa_reg   <= cmpa_next;
      cmpp_reg   <= cmpp_next;
      cnt_reg    <= cnt_next;
      pre_reg    <= pre_next;
      on_d_reg   <= on_d_next;
      pin_d_reg  <= pin_d_next;
      lvl_reg    <= lvl_next;
      out_reg    <= out_next;
      oen_reg    <= oen_next;
      flag_reg   <= flag_next;
      apulse_reg <= apulse_next;
      ppulse_reg <= ppulse_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
    end
  end

  // Outputs
  assign pready        = 1'b1;
  assign prdata        = rdata_reg;
  assign pslverr       = err_reg && psel && penable;
  assign timer_out     = out_reg;
  assign timer_out_en  = oen_reg;
  assign a_match_pulse = apulse_reg;
  assign p_match_pulse = ppulse_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_restart;
    on_rise |=> (cnt_reg == 16'h0000);
  endproperty
  a_restart: assert property (p_restart) // [R22]
    else $error("Counter not cleared on enable edge");

  property p_pause_hold;
    (pause && on && !on_rise) |=> (cnt_reg == $past(cnt_reg));
  endproperty
  a_pause_hold: assert property (p_pause_hold) // [R23]
    else $error("Counter moved while paused");

  property p_count_step;
    (on && !pause && !on_rise && tick && !clr)
      |=> (cnt_reg == $past(cnt_reg) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) // [R25]
    else $error("Counter did not step by one");

  property p_a_pulse;
    a_hit |=> a_match_pulse && flag_reg[0];
  endproperty
  a_a_pulse: assert property (p_a_pulse) // [R26]
    else $error("A match not flagged");

  property p_no_p_flag;
    (ctrl1_reg.mode_select != stc_pkg::MODE_PWM
     && ctrl1_reg.clear_select && $stable(ctrl1_reg)) |=> !p_match_pulse;
  endproperty
  a_no_p_flag: assert property (p_no_p_flag) // [R8]
    else $error("P flag raised with A clearing");

  property p_p_period;
    (p_hit && cmpp_reg == 8'h00) |-> (cnt_reg == 16'hffff);
  endproperty
  a_p_period: assert property (p_p_period) // [R4]
    else $error("P zero match away from overflow");

  property p_init_level;
    (on_rise && ctrl1_reg.mode_select == stc_pkg::MODE_COMPARE
     && $stable(ctrl1_reg))
      |=> (timer_out == (ctrl1_reg.output_control
                         ^ ctrl1_reg.output_polarity));
  endproperty
  a_init_level: assert property (p_init_level) // [R12]
    else $error("Pin not set to initial level");

  property p_pin_only_a;
    (ctrl1_reg.mode_select == stc_pkg::MODE_COMPARE && !a_hit && !on_rise
     && $stable(ctrl1_reg)) |=> $stable(lvl_reg);
  endproperty
  a_pin_only_a: assert property (p_pin_only_a) // [R10]
    else $error("Pin changed without A match");

  property p_timer_free;
    (ctrl1_reg.mode_select == stc_pkg::MODE_TIMER) |=> !timer_out_en;
  endproperty
  a_timer_free: assert property (p_timer_free) // [R13]
    else $error("Pin driven in timer mode");

endmodule

`default_nettype wire

// file: verification/stc_timer_tb_top.sv
// Purpose: Self-checking bench for the standard timer over APB
// Assumes: Counter clock pclk/1 selected so one tick is one pclk
// Notes:   Random compare values from a fixed seed, corner cases mixed in
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) check((g) === (e));

module stc_timer_tb_top;
  // ==========================================================
  // Signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        count_pin_in;
  logic        timer_out;
  logic        timer_out_en;
  logic        a_match_pulse;
  logic        p_match_pulse;
  int          miscompares;
  int          total_checks;
  int          cyc;
  logic [31:0] q;
  logic        e;
  int          hi;
  int          na;
  int          np;
  int          k;
  logic [15:0] a;
  logic [7:0]  p;
  logic [1:0]  fns [4];
  logic [1:0]  pfn [3];
  stc_pkg::stc_ctrl1_t c1;

  // ==========================================================
  // Device under test
  stc_timer i_stc_timer (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .pready        (pready),
    .prdata        (prdata),
    .pslverr       (pslverr),
    .count_pin_in  (count_pin_in),
    .timer_out     (timer_out),
    .timer_out_en  (timer_out_en),
    .a_match_pulse (a_match_pulse),
    .p_match_pulse (p_match_pulse)
  );

  // 10 MHz clock
  always #50 pclk = ~pclk;

  // Hang guard; the whole sequence needs well under this
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input bit ok);
    total_checks++;
    if (!ok)
    begin
      miscompares++;
      $display("wrong value at %0t: mismatch", $time);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stop, program, then start so the start is a counter-on rising edge
  task automatic cfg(input stc_pkg::stc_ctrl1_t c, input logic [15:0] av,
                     input logic [7:0] pv);
    apb(1'b1, stc_pkg::OFS_CONTROL0, 32'h0);
    apb(1'b1, stc_pkg::OFS_CONTROL1, {24'h0, c});
    apb(1'b1, stc_pkg::OFS_CMPA_LOW, {24'h0, av[7:0]});
    apb(1'b1, stc_pkg::OFS_CMPA_HIGH, {24'h0, av[15:8]});
    apb(1'b1, stc_pkg::OFS_CMPP, {24'h0, pv});
    apb(1'b1, stc_pkg::OFS_CONTROL0, {24'h0, 1'b0, stc_pkg::CK_DIV1, 4'h8});
  endtask

  task automatic meas(input int n);
    hi = 0;
    na = 0;
    np = 0;
    repeat (n)
    begin
      @(posedge pclk);
      hi += (timer_out === 1'b1);
      na += (a_match_pulse === 1'b1);
      np += (p_match_pulse === 1'b1);
    end
  endtask

  // Bounded wait for a match pulse, sel 0 for A and 1 for P
  task automatic wait_m(input bit sel);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while ((sel ? p_match_pulse : a_match_pulse) !== 1'b1 && k < 5000);
    check(k < 5000);
  endtask

  // High cycles in 1024 ticks for swap 0, period 256, active high
  function automatic int pwm_hi(input int av, input logic [1:0] f,
                                input logic pol);
    int h;
    h = (f == stc_pkg::FN_PWM_ON) ? 1024 : (f == stc_pkg::FN_PWM_OFF) ? 0 :
        (av >= 256) ? 1024 : 4 * av;
    return pol ? 1024 - h : h;
  endfunction

  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; count_pin_in = 1'b0;
    miscompares = 0; total_checks = 0; cyc = 0;
    fns = '{stc_pkg::FN_NONE, stc_pkg::FN_LOW, stc_pkg::FN_HIGH,
            stc_pkg::FN_TOGGLE};
    pfn = '{stc_pkg::FN_PWM_OFF, stc_pkg::FN_PWM_ON, stc_pkg::FN_PWM};
    void'($urandom(32'hf858));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, read-only counter byte, unmapped place
    apb(1'b0, stc_pkg::OFS_CNT_HIGH, 32'h0); `CHK(q, 32'h0)
    apb(1'b0, stc_pkg::OFS_CMPA_LOW, 32'h0); `CHK(q, 32'h0)
    apb(1'b0, stc_pkg::OFS_CMPA_HIGH, 32'h0); `CHK(q, 32'h0)
    apb(1'b0, stc_pkg::OFS_CMPP, 32'h0); `CHK(q, 32'h0)
    apb(1'b1, stc_pkg::OFS_CNT_HIGH, 32'h5a);
    apb(1'b0, stc_pkg::OFS_CNT_HIGH, 32'h0); `CHK(q, 32'h0)
    apb(1'b1, 8'h20, 32'h33);
    apb(1'b0, 8'h20, 32'h0); `CHK({e, q}, 33'h100000000)
    a = 16'($urandom);
    p = 8'($urandom);
    apb(1'b1, stc_pkg::OFS_CMPA_LOW, {24'h0, a[7:0]});
    apb(1'b1, stc_pkg::OFS_CMPA_HIGH, {24'h0, a[15:8]});
    apb(1'b1, stc_pkg::OFS_CMPP, {24'h0, p});
    apb(1'b0, stc_pkg::OFS_CMPA_LOW, 32'h0); `CHK(q, {24'h0, a[7:0]})
    apb(1'b0, stc_pkg::OFS_CMPA_HIGH, 32'h0); `CHK(q, {24'h0, a[15:8]})
    apb(1'b0, stc_pkg::OFS_CMPP, 32'h0); `CHK(q, {24'h0, p})
    // Compare mode, clear on A, every pin function, P below A
    for (int i = 0; i < 8; i++)
    begin
      c1 = '{stc_pkg::MODE_COMPARE, fns[i % 4], 1'(i / 4), 1'b0, 1'b0, 1'b1};
      a = 16'(300 + $urandom_range(500));   // Never zero here
      cfg(c1, a, 8'h01);
      repeat (2) @(posedge pclk);
      `CHK({timer_out_en, timer_out}, {1'b1, c1.output_control})
      wait_m(1'b0);
      repeat (3) @(posedge pclk);
      case (fns[i % 4])
        stc_pkg::FN_NONE:  `CHK(timer_out, c1.output_control)
        stc_pkg::FN_LOW:   `CHK(timer_out, 1'b0)
        stc_pkg::FN_HIGH:  `CHK(timer_out, 1'b1)
        default:           `CHK(timer_out, ~c1.output_control)
      endcase
      meas(2 * a + 20);
      `CHK(np, 0)
      check(na >= 2);
    end
    // Clear on P: period P times 256, pin untouched by P matches
    for (int i = 0; i < 3; i++)
    begin
      p = 8'(1 + $urandom_range(2));
      c1 = '{stc_pkg::MODE_COMPARE, stc_pkg::FN_NONE, 1'b1, 1'b0, 1'b0, 1'b0};
      cfg(c1, 16'h0005, p);
      wait_m(1'b1);
      meas(p * 256);
      `CHK(np, 1)
      `CHK(na, 1)
      `CHK(hi, p * 256)
    end
    // Timer mode: flags as compare mode, pin not driven
    c1 = '{stc_pkg::MODE_TIMER, stc_pkg::FN_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b0};
    cfg(c1, 16'h0010, 8'h01);
    meas(600);
    `CHK({timer_out_en, np, na}, {1'b0, 32'd2, 32'd3})
    // Counter byte, pause, off and restart, run with P of zero
    c1 = '{stc_pkg::MODE_COMPARE, stc_pkg::FN_NONE, 1'b0, 1'b0, 1'b0, 1'b0};
    cfg(c1, 16'hf000, 8'h00);
    repeat (300) @(posedge pclk);
    apb(1'b0, stc_pkg::OFS_CNT_HIGH, 32'h0); `CHK(q, 32'h1)
    apb(1'b1, stc_pkg::OFS_CONTROL0, 32'h98);
    apb(1'b0, stc_pkg::OFS_CNT_LOW, 32'h0);
    hi = int'(q);
    repeat (50) @(posedge pclk);
    apb(1'b0, stc_pkg::OFS_CNT_LOW, 32'h0); `CHK(int'(q), hi)
    apb(1'b1, stc_pkg::OFS_CONTROL0, 32'h18);
    repeat (50) @(posedge pclk);
    apb(1'b1, stc_pkg::OFS_CONTROL0, 32'h10);
    apb(1'b0, stc_pkg::OFS_CNT_LOW, 32'h0);
    check(q != 32'(hi));
    hi = int'(q);
    repeat (40) @(posedge pclk);
    apb(1'b0, stc_pkg::OFS_CNT_LOW, 32'h0); `CHK(int'(q), hi)
    apb(1'b1, stc_pkg::OFS_CONTROL0, 32'h18);
    apb(1'b0, stc_pkg::OFS_CNT_HIGH, 32'h0); `CHK(q, 32'h0)
    // PWM, swap 0: forced levels, random and full duties, polarity
    for (int i = 0; i < 8; i++)
    begin
      a = (i < 3) ? 16'(300 + 44 * i) : 16'(1 + $urandom_range(254));
      c1 = '{stc_pkg::MODE_PWM, pfn[i % 3], 1'b1, 1'(i / 4), 1'b0, 1'b1};
      cfg(c1, a, 8'h01);
      repeat (600) @(posedge pclk);
      meas(1024);
      `CHK(hi, pwm_hi(a, pfn[i % 3], c1.output_polarity))
      `CHK(np, 4)
      `CHK(na, (a < 256) ? 4 : 0)
    end
    // PWM, swap 1 with P of zero: full duty
    c1 = '{stc_pkg::MODE_PWM, stc_pkg::FN_PWM, 1'b1, 1'b0, 1'b1, 1'b0};
    cfg(c1, 16'd200, 8'h00);
    repeat (400) @(posedge pclk);
    meas(1000);
    `CHK(hi, 1000)
    `CHK(na, 5)
    // PWM, swap 1 with P of one: period from A, duty 256 ticks
    a = 16'(300 + $urandom_range(300));
    cfg(c1, a, 8'h01);
    repeat (700) @(posedge pclk);
    meas(2 * a);
    `CHK(hi, 512)
    `CHK({np, na}, {32'd2, 32'd2})
    complete_run();
  end
endmodule

`default_nettype wire
